// ### rpt_top.sv
// Operation
// - mode field picks none, latch, hiccup, six retries
// - bit 13 enables average detector
// - average fault after blanking in bits 12:5
// - bit 4 enables peak detector
// - peak fault after blanking bits 3:0, 200ns steps
// - reserved bits ignored, read back zero
// - droop release waits bits 12:8, 200ns steps
// - completion packet waits bits 7:0, 100ns steps
// - reading is four times current minus twice offset
// - current offset resets to zero
// - adc sample scaled by gain bits 9:0
// - load-line fifth taken from bits 3:0
//
// Purpose: rail 2 protection and timing configuration with its timers
// Assumes: command port driven by the management-bus front end on CORE_CLK
// Notes: comparator and reference status pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "rpt_consts.svh"
module rpt_top
    import rpt_pkg::*;
#(
    parameter int ADC_W = 12,
    parameter int GAIN_SHIFT = 8,
    parameter int HICCUP_CYC = `RPT_CYC_HICCUP
) (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic CMD_WR,
    input wire logic CMD_RD,
    input wire logic [7:0] CMD_PAGE,
    input wire logic [7:0] CMD_CODE,
    input wire logic [15:0] CMD_WDATA,
    output logic [15:0] CMD_RDATA,
    output logic CMD_ACK,
    output logic CMD_NACK,
    input wire logic AVG_OVER_THRESHOLD,
    input wire logic PEAK_OVER_THRESHOLD,
    input wire logic REF_AT_TARGET,
    input wire logic REF_AT_TARGET_DROOP,
    input wire logic ADC_VALID,
    input wire logic [ADC_W-1:0] ADC_DATA,
    output logic OVERCURRENT_FAULT_FLAG,
    output logic RAIL_OFF,
    output logic DROOP_RELEASE,
    output logic VOLTAGE_CHANGE_COMPLETE_PACKET,
    output logic [15:0] CURRENT_READING,
    output logic [3:0] LOADLINE_FIFTH_SETTING
);
    localparam int STEP_W = 2;
    localparam int AVG_W = 8;
    localparam int HIC_W = 16;
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(`RPT_CYC_STEP - 1);
    localparam logic [AVG_W-1:0] AVG_LAST = AVG_W'(`RPT_STEPS_AVG - 1);
    localparam logic [HIC_W-1:0] HIC_LAST = HIC_W'(HICCUP_CYC - 1);

    // register storage
    logic [15:0] ocp_q;
    logic [15:0] delay_q;
    logic [15:0] cal_q;
    logic [15:0] loadline_q;
    rpt_ocp_cfg_t ocp;
    rpt_delay_cfg_t dly;
    rpt_cal_cfg_t cal;

    assign ocp = rpt_ocp_cfg_t'(ocp_q);
    assign dly = rpt_delay_cfg_t'(delay_q);
    assign cal = rpt_cal_cfg_t'(cal_q);

    // command decode
    wire page_hit = (CMD_PAGE == `RPT_PAGE);
    wire hit_ocp = page_hit && (CMD_CODE == `RPT_CMD_OCP);
    wire hit_delay = page_hit && (CMD_CODE == `RPT_CMD_DELAY);
    wire hit_cal = page_hit && (CMD_CODE == `RPT_CMD_CAL);
    wire hit_ll = page_hit && (CMD_CODE == `RPT_CMD_LOADLINE);
    wire hit_any = hit_ocp || hit_delay || hit_cal || hit_ll;
    wire access = CMD_WR || CMD_RD;

    wire logic [15:0] rd_mux =
        hit_ocp ? (ocp_q & `RPT_MASK_OCP) :
        hit_delay ? (delay_q & `RPT_MASK_DELAY) :
        hit_cal ? (cal_q & `RPT_MASK_CAL) :
        hit_ll ? (loadline_q & `RPT_MASK_LOADLINE) : 16'h0000;

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ocp_q <= `RPT_RST_OCP;
            delay_q <= `RPT_RST_DELAY;
            cal_q <= `RPT_RST_CAL;
            loadline_q <= `RPT_RST_LOADLINE;
        end else if (CMD_WR) begin
            if (hit_ocp) begin
                ocp_q <= CMD_WDATA & `RPT_MASK_OCP;
            end
            if (hit_delay) begin
                delay_q <= CMD_WDATA & `RPT_MASK_DELAY;
            end
            if (hit_cal) begin
                cal_q <= CMD_WDATA & `RPT_MASK_CAL;
            end
            if (hit_ll) begin
                loadline_q <= CMD_WDATA & `RPT_MASK_LOADLINE;
            end
        end
    end

    // answer one cycle after the request; writes to a known code ack too
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CMD_RDATA <= 16'h0000;
            CMD_ACK <= 1'b0;
            CMD_NACK <= 1'b0;
        end else begin
            CMD_RDATA <= CMD_RD ? rd_mux : CMD_RDATA;
            CMD_ACK <= access && hit_any;
            CMD_NACK <= access && !hit_any;
        end
    end

    // two-flop synchronisers for the asynchronous status pins
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {REF_AT_TARGET_DROOP, REF_AT_TARGET, PEAK_OVER_THRESHOLD,
                        AVG_OVER_THRESHOLD};
            sync2_q <= sync1_q;
        end
    end

    wire avg_over = sync2_q[0];
    wire peak_over = sync2_q[1];
    wire at_target = sync2_q[2];
    wire at_droop = sync2_q[3];

    // tick dividers: 100 ns, 200 ns and 20 us enables
    logic [STEP_W-1:0] step_cnt_q;
    logic half_q;
    logic [AVG_W-1:0] avg_cnt_q;
    logic tick_100_q;
    logic tick_200_q;
    logic tick_20u_q;
    wire step_end = (step_cnt_q == STEP_LAST);

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            step_cnt_q <= '0;
            half_q <= 1'b0;
            avg_cnt_q <= '0;
            tick_100_q <= 1'b0;
            tick_200_q <= 1'b0;
            tick_20u_q <= 1'b0;
        end else begin
            step_cnt_q <= step_end ? '0 : step_cnt_q + 1'b1;
            half_q <= step_end ? !half_q : half_q;
            avg_cnt_q <= !step_end ? avg_cnt_q : (avg_cnt_q == AVG_LAST) ? '0 :
                         avg_cnt_q + 1'b1;
            tick_100_q <= step_end;
            tick_200_q <= step_end && half_q;
            tick_20u_q <= step_end && (avg_cnt_q == AVG_LAST);
        end
    end

    // blanking timers; a disabled detector never counts
    logic avg_expired;
    logic peak_expired;
    logic droop_expired;
    logic complete_expired;
    wire avg_active = ocp.average_overcurrent_enable && avg_over;
    wire peak_active = ocp.peak_overcurrent_enable && peak_over;

    rpt_timer #(.W(8)) u_avg (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .tick(tick_20u_q),
        .active(avg_active),
        .limit(ocp.average_overcurrent_blanking),
        .expired(avg_expired)
    );

    rpt_timer #(.W(4)) u_peak (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .tick(tick_200_q),
        .active(peak_active),
        .limit(ocp.peak_overcurrent_blanking),
        .expired(peak_expired)
    );

    rpt_timer #(.W(5)) u_droop (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .tick(tick_200_q),
        .active(at_droop),
        .limit(dly.droop_release_delay),
        .expired(droop_expired)
    );

    rpt_timer #(.W(8)) u_complete (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .tick(tick_100_q),
        .active(at_target),
        .limit(dly.change_complete_delay),
        .expired(complete_expired)
    );

    // fault response machine, one shared mode for both detectors
    wire fault_now = avg_expired || peak_expired;
    rpt_rail_state_t state_q;
    rpt_rail_state_t state_d;
    logic [HIC_W-1:0] hic_cnt_q;
    logic [2:0] retry_q;
    logic fault_d1_q;
    wire fault_rise = fault_now && !fault_d1_q;
    wire retry_spent = (retry_q == `RPT_RETRY_LIMIT);
    wire wait_done = (hic_cnt_q == HIC_LAST);

    always_comb begin
        state_d = state_q;
        case (state_q)
            RPT_ST_ON: begin
                if (fault_rise) begin
                    case (ocp.overcurrent_response_select)
                        `RPT_MODE_LATCH: state_d = RPT_ST_LATCHED;
                        `RPT_MODE_HICCUP: state_d = RPT_ST_WAIT;
                        `RPT_MODE_RETRY: state_d = retry_spent ? RPT_ST_LATCHED :
                                                   RPT_ST_WAIT;
                        default: state_d = RPT_ST_ON;
                    endcase
                end
            end
            RPT_ST_WAIT: begin
                if (wait_done) begin
                    state_d = RPT_ST_ON;
                end
            end
            RPT_ST_LATCHED: state_d = RPT_ST_LATCHED;
            default: state_d = RPT_ST_ON;
        endcase
    end

    // latched off holds until reset: nothing in this block restarts the rail
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= RPT_ST_ON;
            hic_cnt_q <= '0;
            retry_q <= 3'h0;
            fault_d1_q <= 1'b0;
            RAIL_OFF <= 1'b0;
            OVERCURRENT_FAULT_FLAG <= 1'b0;
        end else begin
            state_q <= state_d;
            hic_cnt_q <= (state_q == RPT_ST_WAIT && !wait_done) ? hic_cnt_q + 1'b1 : '0;
            retry_q <= (state_q == RPT_ST_ON && state_d == RPT_ST_WAIT &&
                        ocp.overcurrent_response_select == `RPT_MODE_RETRY) ?
                       retry_q + 1'b1 : retry_q;
            fault_d1_q <= fault_now;
            RAIL_OFF <= (state_d != RPT_ST_ON);
            OVERCURRENT_FAULT_FLAG <= fault_now;
        end
    end

    // reference timing outputs
    logic complete_d1_q;

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            complete_d1_q <= 1'b0;
            DROOP_RELEASE <= 1'b0;
            VOLTAGE_CHANGE_COMPLETE_PACKET <= 1'b0;
        end else begin
            complete_d1_q <= complete_expired;
            DROOP_RELEASE <= droop_expired;
            VOLTAGE_CHANGE_COMPLETE_PACKET <= complete_expired && !complete_d1_q;
        end
    end

    // current report: gain gives quarter-amp units, offset is half-amp units
    wire logic [ADC_W+9:0] product = ADC_W'(ADC_DATA) * cal.gain;
    wire logic [ADC_W+9:0] scaled = product >> GAIN_SHIFT;
    wire logic [16:0] diff = {1'b0, scaled[15:0]} - {10'h000, cal.offset, 1'b0};

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CURRENT_READING <= 16'h0000;
            LOADLINE_FIFTH_SETTING <= 4'h0;
        end else begin
            if (ADC_VALID) begin
                CURRENT_READING <= diff[16] ? 16'h0000 : diff[15:0];
            end
            LOADLINE_FIFTH_SETTING <= loadline_q[3:0];
        end
    end
endmodule
`default_nettype wire

// ### rpt_consts.svh
// Purpose: offsets, masks, reset values and timing counts
// Assumes: 40 MHz core clock
// Notes: definitions only
`ifndef RPT_CONSTS_SVH
`define RPT_CONSTS_SVH

`define RPT_PAGE 8'h01
`define RPT_CMD_OCP 8'hC2
`define RPT_CMD_DELAY 8'hC3
`define RPT_CMD_CAL 8'hC5
`define RPT_CMD_LOADLINE 8'hC6

`define RPT_MASK_OCP 16'hFFFF
`define RPT_MASK_DELAY 16'h1FFF
`define RPT_MASK_CAL 16'hFFFF
`define RPT_MASK_LOADLINE 16'h000F

`define RPT_RST_OCP 16'h0000
`define RPT_RST_DELAY 16'h0500
`define RPT_RST_CAL 16'h0000
`define RPT_RST_LOADLINE 16'h0000

`define RPT_MODE_NONE 2'h0
`define RPT_MODE_LATCH 2'h1
`define RPT_MODE_HICCUP 2'h2
`define RPT_MODE_RETRY 2'h3
`define RPT_RETRY_LIMIT 3'h6

`define RPT_CLK_MHZ 40
`define RPT_T_STEP_NS 100
`define RPT_CYC_STEP ((`RPT_T_STEP_NS * `RPT_CLK_MHZ) / 1000)
`define RPT_T_PEAK_NS 200
`define RPT_STEPS_PEAK (`RPT_T_PEAK_NS / `RPT_T_STEP_NS)
`define RPT_T_AVG_NS 20000
`define RPT_STEPS_AVG (`RPT_T_AVG_NS / `RPT_T_STEP_NS)
`define RPT_T_HICCUP_US 20
`define RPT_CYC_HICCUP (`RPT_T_HICCUP_US * `RPT_CLK_MHZ)

`endif

// ### rpt_pkg.sv
// Purpose: shared types for the rail 2 protection and timing block
// Assumes: nothing
// Notes: field structs match register layouts bit for bit
package rpt_pkg;

    typedef struct packed {
        logic [1:0] overcurrent_response_select;
        logic average_overcurrent_enable;
        logic [7:0] average_overcurrent_blanking;
        logic peak_overcurrent_enable;
        logic [3:0] peak_overcurrent_blanking;
    } rpt_ocp_cfg_t;

    typedef struct packed {
        logic [2:0] unused;
        logic [4:0] droop_release_delay;
        logic [7:0] change_complete_delay;
    } rpt_delay_cfg_t;

    typedef struct packed {
        logic [5:0] offset;
        logic [9:0] gain;
    } rpt_cal_cfg_t;

    typedef enum logic [1:0] {
        RPT_ST_ON = 2'b00,
        RPT_ST_WAIT = 2'b01,
        RPT_ST_LATCHED = 2'b10
    } rpt_rail_state_t;

endpackage

// ### rpt_timer.sv
// Purpose: qualified-level timer counting slow ticks up to a limit
// Assumes: tick is a one-cycle enable on the core clock
// Notes: may run long by up to one tick period, never short
`timescale 1ns/1ps
`default_nettype none
module rpt_timer #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic active,
    input wire logic [W-1:0] limit,
    output logic expired
);
    logic [W:0] cnt_q;
    logic [W:0] cnt_d;
    logic reached;

    // one tick past the limit: a free-running first tick cannot cut the time short
    assign reached = (cnt_q > {1'b0, limit});
    // dropping the condition restarts the count so no stale time survives
    assign cnt_d = !active ? '0 : (tick && !reached) ? cnt_q + 1'b1 : cnt_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            expired <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            expired <= active && reached;
        end
    end
endmodule
`default_nettype wire

// ### rpt_asserts.sv
// Purpose: port checks for rpt_top
// Assumes: one clock domain
// Notes: shadows the protection word to know the mode
`timescale 1ns/1ps
`default_nettype none
module rpt_asserts (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic CMD_WR,
    input wire logic CMD_RD,
    input wire logic [7:0] CMD_PAGE,
    input wire logic [7:0] CMD_CODE,
    input wire logic [15:0] CMD_WDATA,
    input wire logic [15:0] CMD_RDATA,
    input wire logic CMD_ACK,
    input wire logic CMD_NACK,
    input wire logic AVG_OVER_THRESHOLD,
    input wire logic PEAK_OVER_THRESHOLD,
    input wire logic REF_AT_TARGET,
    input wire logic REF_AT_TARGET_DROOP,
    input wire logic OVERCURRENT_FAULT_FLAG,
    input wire logic RAIL_OFF,
    input wire logic DROOP_RELEASE,
    input wire logic VOLTAGE_CHANGE_COMPLETE_PACKET,
    input wire logic [3:0] LOADLINE_FIFTH_SETTING
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    logic [15:0] ocp_q;
    wire logic pg1 = CMD_PAGE == 8'h01;
    wire logic [1:0] mode = ocp_q[15:14];
    wire logic en_any = ocp_q[13] || ocp_q[4];
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N)
            ocp_q <= 16'h0000;
        else if (CMD_WR && pg1 && CMD_CODE == 8'hC2)
            ocp_q <= CMD_WDATA;
    end
    sequence s_fault;
        $rose(OVERCURRENT_FAULT_FLAG);
    endsequence
    sequence s_ll_write;
        CMD_WR && pg1 && CMD_CODE == 8'hC6;
    endsequence
    property p_no_action;
        s_fault ##0 (mode == 2'h0 && !$past(RAIL_OFF)) |-> !RAIL_OFF;
    endproperty
    a_no_action: assert property (p_no_action) else $error("rail off in no-action mode");
    property p_latch;
        s_fault ##0 mode == 2'h1 |-> RAIL_OFF [*8];
    endproperty
    a_latch: assert property (p_latch) else $error("latched rail came back");
    property p_cause;
        s_fault |-> $past(AVG_OVER_THRESHOLD || PEAK_OVER_THRESHOLD, 4);
    endproperty
    a_cause: assert property (p_cause) else $error("fault without current");
    property p_disabled;
        (!en_any) [*6] |-> !$rose(OVERCURRENT_FAULT_FLAG);
    endproperty
    a_disabled: assert property (p_disabled) else $error("fault while disabled");
    property p_packet;
        VOLTAGE_CHANGE_COMPLETE_PACKET |-> $past(REF_AT_TARGET, 4)
            ##1 !VOLTAGE_CHANGE_COMPLETE_PACKET;
    endproperty
    a_packet: assert property (p_packet) else $error("bad completion packet");
    property p_droop;
        DROOP_RELEASE |-> $past(REF_AT_TARGET_DROOP, 4);
    endproperty
    a_droop: assert property (p_droop) else $error("droop release uncaused");
    property p_reserved;
        CMD_RD && pg1 && CMD_CODE == 8'hC3 |=> CMD_ACK && CMD_RDATA[15:13] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
    property p_nack;
        (CMD_WR || CMD_RD) && !pg1 |=> CMD_NACK && !CMD_ACK;
    endproperty
    a_nack: assert property (p_nack) else $error("miss on wrong page not refused");
    property p_loadline;
        s_ll_write |-> ##2 LOADLINE_FIFTH_SETTING == $past(CMD_WDATA[3:0], 2);
    endproperty
    a_loadline: assert property (p_loadline) else $error("load-line output wrong");
endmodule
`default_nettype wire

// ### rpt_sense_model.sv
// Purpose: current-monitor sampler feeding the block
// Assumes: go held one cycle per sample
// Notes: data toggles between samples so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module rpt_sense_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [11:0] val,
    output logic valid = 1'b0,
    output logic [11:0] data = 12'h5A5
);
    always @(posedge clk) begin
        valid <= go;
        data <= go ? val : ~data;
    end
endmodule
`default_nettype wire

// ### rpt_top_tb_top.sv
// Purpose: self-checking bench for rpt_top
// Assumes: 40 MHz clock, hiccup cut to 16 cycles
// Notes: inputs change 2 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module rpt_top_tb_top;
    logic CORE_CLK = 1'b0, ARST_N = 1'b0, CMD_WR = 1'b0, CMD_RD = 1'b0;
    logic [7:0] CMD_PAGE = 8'h01, CMD_CODE = 8'h00;
    logic [15:0] CMD_WDATA = 16'h0000;
    logic AVG_OVER_THRESHOLD = 1'b0, PEAK_OVER_THRESHOLD = 1'b0;
    logic REF_AT_TARGET = 1'b0, REF_AT_TARGET_DROOP = 1'b0, adc_go = 1'b0;
    logic [11:0] adc_val = 12'h000;
    logic ADC_VALID, CMD_ACK, CMD_NACK, OVERCURRENT_FAULT_FLAG, RAIL_OFF;
    logic DROOP_RELEASE, VOLTAGE_CHANGE_COMPLETE_PACKET;
    logic [11:0] ADC_DATA;
    logic [15:0] CMD_RDATA, CURRENT_READING;
    logic [3:0] LOADLINE_FIFTH_SETTING;
    int failures = 0;
    int total_checks = 0;
    int n;
    always #12.5 CORE_CLK = ~CORE_CLK;
    rpt_top #(.HICCUP_CYC(16)) i_rpt_top (.CORE_CLK, .ARST_N, .CMD_WR, .CMD_RD, .CMD_PAGE,
        .CMD_CODE, .CMD_WDATA, .CMD_RDATA, .CMD_ACK, .CMD_NACK, .AVG_OVER_THRESHOLD,
        .PEAK_OVER_THRESHOLD, .REF_AT_TARGET, .REF_AT_TARGET_DROOP, .ADC_VALID, .ADC_DATA,
        .OVERCURRENT_FAULT_FLAG, .RAIL_OFF, .DROOP_RELEASE, .VOLTAGE_CHANGE_COMPLETE_PACKET,
        .CURRENT_READING, .LOADLINE_FIFTH_SETTING);
    rpt_sense_model i_rpt_sense_model (.clk(CORE_CLK), .go(adc_go), .val(adc_val),
        .valid(ADC_VALID), .data(ADC_DATA));
    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step(int c);
        repeat (c) @(posedge CORE_CLK);
        #2;
    endtask
    // idle cycle first so strobes never toggle twice in one step
    task automatic acc(logic w, logic [7:0] c, logic [15:0] d);
        step(1);
        CMD_WR = w;
        CMD_RD = !w;
        CMD_CODE = c;
        CMD_WDATA = d;
        step(1);
        CMD_WR = 1'b0;
        CMD_RD = 1'b0;
    endtask
    task automatic rdc(logic [7:0] c, logic [15:0] e);
        acc(1'b0, c, 16'h0000);
        chk("rdata", e, CMD_RDATA);
    endtask
    task automatic waitf(ref logic s, input int lim);
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            step(1);
            n++;
        end
        if (n >= lim) begin
            failures++;
            end_sim();
        end
    endtask
    task automatic rst;
        ARST_N = 1'b0;
        step(6);
        ARST_N = 1'b1;
    endtask
    task automatic t_regs;
        rdc(8'hC2, 16'h0000);
        rdc(8'hC3, 16'h0500);
        rdc(8'hC5, 16'h0000);
        rdc(8'hC6, 16'h0000);
        acc(1'b1, 8'hC3, 16'hFFFF);
        rdc(8'hC3, 16'h1FFF);
        acc(1'b1, 8'hC6, 16'hFFFF);
        rdc(8'hC6, 16'h000F);
        chk("loadline", 16'h000F, 16'(LOADLINE_FIFTH_SETTING));
        CMD_PAGE = 8'h00;
        acc(1'b1, 8'hC2, 16'hFFFF);
        chk("nack page", 16'h0001, 16'(CMD_NACK));
        CMD_PAGE = 8'h01;
        acc(1'b0, 8'hC4, 16'h0000);
        chk("nack code", 16'h0001, 16'(CMD_NACK));
        rdc(8'hC2, 16'h0000);
    endtask
    task automatic t_peak;
        acc(1'b1, 8'hC2, 16'h4012);
        PEAK_OVER_THRESHOLD = 1'b1;
        step(10);
        PEAK_OVER_THRESHOLD = 1'b0;
        step(10);
        chk("early drop", 16'h0000, 16'(OVERCURRENT_FAULT_FLAG));
        PEAK_OVER_THRESHOLD = 1'b1;
        waitf(OVERCURRENT_FAULT_FLAG, 60);
        chk("peak blank", 16'h0001, 16'(n >= 16 && n <= 30));
        chk("latch off", 16'h0001, 16'(RAIL_OFF));
        PEAK_OVER_THRESHOLD = 1'b0;
        step(40);
        chk("still off", 16'h0001, 16'(RAIL_OFF));
        rst();
    endtask
    task automatic t_avg;
        acc(1'b1, 8'hC2, 16'h8000);
        AVG_OVER_THRESHOLD = 1'b1;
        PEAK_OVER_THRESHOLD = 1'b1;
        step(40);
        chk("disabled", 16'h0000, 16'(OVERCURRENT_FAULT_FLAG));
        PEAK_OVER_THRESHOLD = 1'b0;
        acc(1'b1, 8'hC2, 16'hA020);
        waitf(OVERCURRENT_FAULT_FLAG, 1700);
        chk("avg blank", 16'h0001, 16'(n >= 780 && n <= 1610));
        chk("hiccup off", 16'h0001, 16'(RAIL_OFF));
        step(30);
        chk("hiccup on", 16'h0000, 16'(RAIL_OFF));
        AVG_OVER_THRESHOLD = 1'b0;
        step(10);
    endtask
    task automatic t_modes;
        int i;
        acc(1'b1, 8'hC2, 16'h0010);
        PEAK_OVER_THRESHOLD = 1'b1;
        waitf(OVERCURRENT_FAULT_FLAG, 20);
        chk("no action", 16'h0000, 16'(RAIL_OFF));
        PEAK_OVER_THRESHOLD = 1'b0;
        acc(1'b1, 8'hC2, 16'hC010);
        // six faults bounce the rail, the seventh holds it off
        for (i = 0; i < 7; i++) begin
            step(10);
            PEAK_OVER_THRESHOLD = 1'b1;
            waitf(OVERCURRENT_FAULT_FLAG, 20);
            chk("retry off", 16'h0001, 16'(RAIL_OFF));
            step(30);
            chk("retry on", 16'(i == 6), 16'(RAIL_OFF));
            PEAK_OVER_THRESHOLD = 1'b0;
        end
    endtask
    task automatic t_delay;
        acc(1'b1, 8'hC3, 16'h0503);
        REF_AT_TARGET = 1'b1;
        waitf(VOLTAGE_CHANGE_COMPLETE_PACKET, 40);
        chk("complete", 16'h0001, 16'(n >= 12 && n <= 24));
        step(1);
        chk("pulse", 16'h0000, 16'(VOLTAGE_CHANGE_COMPLETE_PACKET));
        REF_AT_TARGET_DROOP = 1'b1;
        waitf(DROOP_RELEASE, 80);
        chk("droop", 16'h0001, 16'(n >= 40 && n <= 56));
        REF_AT_TARGET = 1'b0;
        REF_AT_TARGET_DROOP = 1'b0;
    endtask
    task automatic t_adc(logic [11:0] v, logic [15:0] e);
        adc_val = v;
        adc_go = 1'b1;
        step(1);
        adc_go = 1'b0;
        step(2);
        chk("reading", e, CURRENT_READING);
    endtask
    // gain 256 cancels the shift, offset 2 takes four counts off
    task automatic t_cur;
        acc(1'b1, 8'hC5, 16'h0900);
        t_adc(12'h064, 16'h0060);
        t_adc(12'h002, 16'h0000);
    endtask
    initial begin
        rst();
        t_regs();
        t_peak();
        t_avg();
        t_modes();
        t_delay();
        t_cur();
        end_sim();
    end
endmodule
bind rpt_top rpt_asserts i_rpt_asserts (.CORE_CLK, .ARST_N, .CMD_WR, .CMD_RD, .CMD_PAGE,
    .CMD_CODE, .CMD_WDATA, .CMD_RDATA, .CMD_ACK, .CMD_NACK, .AVG_OVER_THRESHOLD,
    .PEAK_OVER_THRESHOLD, .REF_AT_TARGET, .REF_AT_TARGET_DROOP, .OVERCURRENT_FAULT_FLAG,
    .RAIL_OFF, .DROOP_RELEASE, .VOLTAGE_CHANGE_COMPLETE_PACKET, .LOADLINE_FIFTH_SETTING);
`default_nettype wire
